// *** mps_tx_consts.svh ***
// Register offsets, field positions, codes and constants of the serial block.
`ifndef MPS_TX_CONSTS_SVH
`define MPS_TX_CONSTS_SVH
`define ADDR_TX_CONTROL 8'h00
`define ADDR_SYNC_FIRST 8'h04
`define ADDR_SYNC_SECOND 8'h08
`define ADDR_PRIMARY_STATUS 8'h0c
`define ADDR_MODE 8'h10
`define ADDR_COMMAND 8'h14
`define ADDR_TX_DATA 8'h18
`define ADDR_VECTOR 8'h1c
`define TC_RESET 8'h00
`define MODE_RESET 8'h00
`define MODE_STOP2 1
`define MODE_FMT_LO 2
`define MODE_RATE_LO 4
`define MODE_VECTORED 6
`define CMD_HUNT 0
`define CMD_RST_EXT 1
`define CMD_EOI 2
`define CMD_RST_IDLE 3
`define FMT_MONO 2'h0
`define FMT_BISYNC 2'h1
`define FMT_HDLC 2'h2
`define FMT_EXT 2'h3
`define HDLC_FLAG 8'h7e
`define CRC16_REV 16'ha001
`define CCITT_REV 16'h8408
`define CRC_INIT 16'h0000
`define HDLC_STUFF_ONES 3'h5
`define HDLC_ABORT_ONES 3'h7
`define ASYNC_CHAR_BITS 10'h00a
`define PIN_TXC 0
`define PIN_RXC 1
`define PIN_RXD 2
`define PIN_DCD 3
`define PIN_CTS 4
`define PIN_SYNC 5
`define PIN_PRI 6
`define PIN_ACK 7
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3
`endif

// *** mps_tx_pkg.sv ***
// Types shared by the serial transmit and status block.
package mps_tx_pkg;
  typedef struct packed {
    logic dtr;
    logic [1:0] len;
    logic brk;
    logic tx_en;
    logic poly16;
    logic rts;
    logic crc_en;
  } tx_ctrl_s;
  typedef struct packed {
    logic brk_abort;
    logic idle_crc;
    logic cts;
    logic sync;
    logic dcd;
    logic tbe;
    logic int_pend;
    logic rx_avail;
  } status_s;
  typedef enum logic [1:0] {PH_OFF, PH_IDLE, PH_DATA, PH_CRC} tx_phase_e;
endpackage : mps_tx_pkg

// *** mps_tx_status.sv ***
// Transmit control, sync patterns and primary status of one serial channel.
//
// Our own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/100ps
`include "mps_tx_consts.svh"
// What this block does
// - CRC enable change takes effect at next buffer-to-shifter load.
// - Sync modes: request and ready bits drive active-low pins low.
// - Async: clearing request bit raises pin only when transmitter empty.
// - Polynomial bit picks CRC-16 when one, CCITT when zero.
// - After reset line marks; transmitter off until enable bit set.
// - Async disable finishes current character before marking.
// - Sync data disable sends current character; HDLC mark zero-inserted.
// - CRC-phase disable substitutes pattern bits; idle disable ends pattern.
// - Break bit forces line low at once; transmitter keeps running.
// - Length field: 00 short, 01 seven, 10 six, 11 eight bits.
// - Short characters encode their bit count in the upper pattern.
// - First sync byte: idle character, bisync low half, HDLC address.
// - Second sync byte: mono match, bisync high half; HDLC sends the fixed HDLC_FLAG, not this byte.
// - Receive-available flag follows characters waiting in receive buffer.
// - Channel A interrupt pending: set on poll or acknowledge, cleared EOI.
// - Transmit-buffer-empty set when buffer empty, except during CRC.
// - External status bits latch on change until reset command.
// - Carrier and clear-to-send status show inverted inputs.
// - Async/external: sync status is inverted sync input.
// - Character modes: sync status is one during hunt.
// - Idle latch set at reset and when CRC starts; HDLC write clears.
// - Break/abort from long low line or seven ones.
// - Enter-hunt command forces the receiver back into hunt.
module mps_tx_status #(
  parameter bit CHANNEL_A = 1'b1
) (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst_n,
  // AXI4-Lite register port.
  input wire logic i_awvalid,
  input wire logic [7:0] i_awaddr,
  input wire logic i_wvalid,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_bready,
  input wire logic i_arvalid,
  input wire logic [7:0] i_araddr,
  input wire logic i_rready,
  output logic o_awready,
  output logic o_wready,
  output logic o_bvalid,
  output logic [1:0] o_bresp,
  output logic o_arready,
  output logic o_rvalid,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  // Serial line and modem pins.
  input wire logic i_txc,
  input wire logic i_rxc,
  input wire logic i_rxd,
  input wire logic i_dcd_n,
  input wire logic i_cts_n,
  input wire logic i_sync_n,
  output logic o_txd,
  output logic o_rts_n,
  output logic o_dtr_n,
  // Interrupt chain pins and receiver/interrupt logic on this clock.
  input wire logic i_priority_chain_in_n,
  input wire logic i_interrupt_ack_strobe_n,
  input wire logic i_int_request,
  input wire logic i_other_pending,
  input wire logic i_rx_char_avail,
  input wire logic i_sync_found,
  input wire logic [7:0] i_vector_readback,
  output logic o_ext_status_req,
  output logic o_rx_hunt
);
  import mps_tx_pkg::*;

  tx_ctrl_s tc_r;
  logic [7:0] sync1_r, sync2_r, mode_r, buf_r, pin_m_r, pin_r, pin_d_r;
  logic buf_full_r, crc_on_r, idle_r, hunt_r, armed_r, int_pend_r;
  logic mark_stuff_r, line_r, ack_cnt_r, brk_r;
  logic [4:0] ext_latch_r, ext_prev_r;
  tx_phase_e phase_r;
  logic [17:0] shift_r;
  logic [15:0] pat_sh_r, crc_r;
  logic [4:0] bits_r;
  logic [5:0] div_r;
  logic [2:0] ones_r, rx_ones_r;
  logic [9:0] low_cnt_r;

  // Decode and selection.
  wire wr_go = o_awready & i_awvalid & i_wvalid;
  wire rd_go = o_arready & i_arvalid;
  wire wr_b0 = wr_go & i_wstrb[0];
  wire [7:0] wd = i_wdata[7:0];
  wire wr_tc = wr_b0 & (i_awaddr == `ADDR_TX_CONTROL);
  wire wr_cmd = wr_b0 & (i_awaddr == `ADDR_COMMAND);
  wire wr_dat = wr_b0 & (i_awaddr == `ADDR_TX_DATA) & ~buf_full_r;
  wire cmd_hunt = wr_cmd & wd[`CMD_HUNT];
  wire cmd_ext = wr_cmd & wd[`CMD_RST_EXT];
  wire cmd_eoi = wr_cmd & wd[`CMD_EOI];
  wire cmd_idle = wr_cmd & wd[`CMD_RST_IDLE];
  wire [7:0] aw = i_awaddr;
  wire [7:0] ar = i_araddr;
  wire aw_ok = (aw[1:0] == 2'h0) && (aw <= `ADDR_VECTOR);
  wire ar_ok = (ar[1:0] == 2'h0) && (ar <= `ADDR_VECTOR);
  wire rd_vec = rd_go & (ar == `ADDR_VECTOR);
  wire mode_async = (mode_r[`MODE_STOP2:0] != 2'h0);
  wire [1:0] fmt = mode_r[`MODE_FMT_LO+1:`MODE_FMT_LO];
  wire hdlc = ~mode_async & (fmt == `FMT_HDLC);
  wire [1:0] rate = mode_r[`MODE_RATE_LO+1:`MODE_RATE_LO];
  wire [6:0] factor = (rate == 2'h0) ? 7'h01 : (7'h08 << rate);
  wire txc_fall = pin_d_r[`PIN_TXC] & ~pin_r[`PIN_TXC];
  wire rxc_rise = ~pin_d_r[`PIN_RXC] & pin_r[`PIN_RXC];
  wire ack_lead = pin_d_r[`PIN_ACK] & ~pin_r[`PIN_ACK];
  wire tick = txc_fall & ({1'b0, div_r} == factor - 7'h01);
  wire [15:0] poly = tc_r.poly16 ? `CRC16_REV : `CCITT_REV;
  wire subst = (phase_r == PH_CRC) & ~tc_r.tx_en;
  wire cur_bit = (bits_r == 5'h0) ? 1'b1 : subst ? pat_sh_r[0] : shift_r[0];
  wire stuff_ph = (phase_r == PH_DATA) | (phase_r == PH_CRC);
  wire stuff_zone = hdlc & ((stuff_ph & bits_r != 5'h0) | mark_stuff_r);
  wire stuff = stuff_zone & (ones_r == `HDLC_STUFF_ONES);
  wire crc_step = (phase_r == PH_DATA) & crc_on_r & (bits_r != 5'h0);
  wire [15:0] crc_sh = {1'b0, crc_r[15:1]};
  wire [15:0] crc_upd = crc_sh ^ ((crc_r[0] ^ cur_bit) ? poly : 16'h0);
  wire boundary = tick & ~stuff & (bits_r <= 5'h1);
  wire all_empty = ~buf_full_r & (bits_r == 5'h0);
  // idle pattern per sync format.
  wire bisync = (fmt == `FMT_BISYNC);
  wire [15:0] pat = bisync ? {sync2_r, sync1_r} :
                    (fmt == `FMT_HDLC) ? {2{`HDLC_FLAG}} : {2{sync1_r}};
  wire [4:0] pat_bits = bisync ? 5'h10 : 5'h08;
  wire [3:0] nbits = char_bits(tc_r.len, buf_r);
  wire [7:0] dmask = 8'hff >> (4'h8 - nbits);
  wire [17:0] async_chr = {9'h1ff, buf_r | ~dmask, 1'b0}; // Ones above n stop.
  wire [4:0] stop_bits = mode_r[`MODE_STOP2] ? 5'h2 : 5'h1;
  wire load_dat = boundary & tc_r.tx_en & buf_full_r;
  wire load_crc = boundary & ~load_dat & ~mode_async & tc_r.tx_en &
                  (phase_r == PH_DATA) & crc_on_r & ~idle_r;
  wire sync_live = mode_async | (fmt == `FMT_EXT) ?
                   ~pin_r[`PIN_SYNC] : hunt_r;
  wire [4:0] ext_live = {brk_r, idle_r, ~pin_r[`PIN_CTS], sync_live,
                         ~pin_r[`PIN_DCD]};
  wire [4:0] ext_diff = ext_live ^ ext_prev_r;
  // The idle latch interrupts only on being set.
  wire ext_change = (ext_diff[4] | ext_diff[2] | ext_diff[1] | ext_diff[0]) |
                    (ext_diff[3] & ext_live[3]);
  status_s st;
  assign st = '{brk_abort: ext_latch_r[4], idle_crc: ext_latch_r[3],
                cts: ext_latch_r[2], sync: ext_latch_r[1],
                dcd: ext_latch_r[0],
                tbe: ~buf_full_r & (phase_r != PH_CRC),
                int_pend: int_pend_r & CHANNEL_A,
                rx_avail: i_rx_char_avail};
  wire [7:0] rd_mux =
    (ar == `ADDR_PRIMARY_STATUS) ? st :
    (ar == `ADDR_MODE) ? mode_r :
    (ar == `ADDR_VECTOR) ? i_vector_readback : 8'h00;

  // Length 00 reads n from the pattern of fill bits above the data.
  function automatic logic [3:0] char_bits(input logic [1:0] len,
                                           input logic [7:0] d);
    logic [3:0] n;
    n = 4'h5;
    case (len)
      2'h1: n = 4'h7;
      2'h2: n = 4'h6;
      2'h3: n = 4'h8;
      default: begin
        if (d[7:1] == 7'h78) n = 4'h1;
        else if (d[7:2] == 6'h38) n = 4'h2;
        else if (d[7:3] == 5'h18) n = 4'h3;
        else if (d[7:4] == 4'h8) n = 4'h4;
      end
    endcase
    return n;
  endfunction : char_bits

  // Pins cross into this clock through two flip-flops.
  always_ff @(posedge i_clk) begin
    pin_m_r <= {i_interrupt_ack_strobe_n, i_priority_chain_in_n, i_sync_n,
                i_cts_n, i_dcd_n, i_rxd, i_rxc, i_txc};
    pin_r <= pin_m_r;
    pin_d_r <= pin_r;
  end

  // Register bus slave: write and read channels.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_awready <= 1'b0;
      o_wready <= 1'b0;
      o_bvalid <= 1'b0;
      o_bresp <= `RESP_OKAY;
      o_arready <= 1'b0;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0;
      o_rresp <= `RESP_OKAY;
    end else begin
      o_awready <= i_awvalid & i_wvalid & ~o_awready & ~o_bvalid;
      o_wready <= i_awvalid & i_wvalid & ~o_awready & ~o_bvalid;
      if (wr_go) begin
        o_bvalid <= 1'b1;
        o_bresp <= aw_ok ? `RESP_OKAY : `RESP_DECERR;
      end else if (i_bready) begin
        o_bvalid <= 1'b0;
      end
      o_arready <= i_arvalid & ~o_arready & ~o_rvalid;
      if (rd_go) begin
        o_rvalid <= 1'b1;
        o_rdata <= {24'h0, rd_mux};
        o_rresp <= ar_ok ? `RESP_OKAY : `RESP_DECERR;
      end else if (i_rready) begin
        o_rvalid <= 1'b0;
      end
    end
  end

  // Software-written registers and the transmit buffer.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      tc_r <= `TC_RESET;
      mode_r <= `MODE_RESET;
      sync1_r <= 8'h00;
      sync2_r <= 8'h00;
      buf_r <= 8'h00;
      buf_full_r <= 1'b0;
    end else begin
      if (wr_tc) tc_r <= wd;
      if (wr_b0 && aw == `ADDR_MODE) mode_r <= wd;
      if (wr_b0 && aw == `ADDR_SYNC_FIRST) sync1_r <= wd;
      if (wr_b0 && aw == `ADDR_SYNC_SECOND) sync2_r <= wd;
      if (wr_dat) buf_r <= wd;
      if (wr_dat) buf_full_r <= 1'b1;
      else if (load_dat) buf_full_r <= 1'b0;
    end
  end

  // Transmitter: bit ticks, shifting, stuffing and character boundaries.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      div_r <= 6'h0;
      phase_r <= PH_OFF;
      shift_r <= 18'h0;
      pat_sh_r <= 16'h0;
      bits_r <= 5'h0;
      crc_r <= `CRC_INIT;
      crc_on_r <= 1'b0;
      ones_r <= 3'h0;
      mark_stuff_r <= 1'b0;
      line_r <= 1'b1;
    end else begin
      if (txc_fall) div_r <= tick ? 6'h0 : div_r + 6'h01;
      if (tc_r.tx_en) mark_stuff_r <= 1'b0;
      if (tick && stuff) begin
        line_r <= 1'b0;
        ones_r <= 3'h0;
      end else if (tick) begin
        line_r <= cur_bit;
        ones_r <= (stuff_zone && cur_bit) ? ones_r + 3'h1 : 3'h0;
        shift_r <= {1'b0, shift_r[17:1]};
        pat_sh_r <= {1'b0, pat_sh_r[15:1]};
        if (bits_r != 5'h0) bits_r <= bits_r - 5'h1;
        if (crc_step) crc_r <= crc_upd;
      end
      if (load_dat && mode_async) begin
        shift_r <= async_chr;
        bits_r <= 5'(nbits) + 5'h1 + stop_bits;
        phase_r <= PH_DATA;
      end else if (load_dat) begin
        shift_r <= {10'h0, buf_r};
        bits_r <= 5'(nbits);
        phase_r <= PH_DATA;
        crc_on_r <= tc_r.crc_en;
        if (phase_r != PH_DATA) crc_r <= `CRC_INIT;
      end else if (load_crc) begin
        shift_r <= {2'h0, crc_step ? crc_upd : crc_r};
        pat_sh_r <= pat;
        bits_r <= 5'h10;
        phase_r <= PH_CRC;
      end else if (boundary && tc_r.tx_en && !mode_async) begin
        shift_r <= {2'h0, pat};
        bits_r <= pat_bits;
        phase_r <= PH_IDLE;
      end else if (boundary) begin
        bits_r <= 5'h0;
        phase_r <= PH_OFF;
        if (hdlc && phase_r == PH_DATA) mark_stuff_r <= 1'b1;
      end
    end
  end

  // Modem outputs, line output with break override, idle latch.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_txd <= 1'b1;
      o_rts_n <= 1'b1;
      o_dtr_n <= 1'b1;
      idle_r <= 1'b1;
    end else begin
      o_txd <= tc_r.brk ? 1'b0 : line_r;
      o_dtr_n <= ~tc_r.dtr;
      if (!mode_async || tc_r.rts) o_rts_n <= ~tc_r.rts;
      else if (all_empty) o_rts_n <= 1'b1;
      if (load_crc) idle_r <= 1'b1;
      else if (cmd_idle || (wr_dat && hdlc)) idle_r <= 1'b0;
    end
  end

  // Receive-side status: hunt, break and abort detection.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      hunt_r <= 1'b1;
      brk_r <= 1'b0;
      low_cnt_r <= 10'h0;
      rx_ones_r <= 3'h0;
    end else begin
      if (cmd_hunt) hunt_r <= 1'b1;
      else if (!mode_async && fmt == `FMT_EXT && !pin_r[`PIN_SYNC])
        hunt_r <= 1'b0;
      else if (i_sync_found) hunt_r <= 1'b0;
      if (mode_async) begin
        if (pin_r[`PIN_RXD]) low_cnt_r <= 10'h0;
        else if (rxc_rise && !brk_r) low_cnt_r <= low_cnt_r + 10'h1;
        if (pin_r[`PIN_RXD]) brk_r <= 1'b0;
        else if (low_cnt_r > `ASYNC_CHAR_BITS * 10'(factor)) brk_r <= 1'b1;
      end else if (hdlc && rxc_rise) begin
        if (!pin_r[`PIN_RXD]) rx_ones_r <= 3'h0;
        else if (rx_ones_r != `HDLC_ABORT_ONES) rx_ones_r <= rx_ones_r + 3'h1;
        brk_r <= pin_r[`PIN_RXD] && rx_ones_r >= 3'h6;
      end else if (!hdlc) begin
        brk_r <= 1'b0;
      end
    end
  end

  // External status latching and interrupt pending.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ext_prev_r <= 5'h0;
      ext_latch_r <= 5'h0;
      armed_r <= 1'b1;
      o_ext_status_req <= 1'b0;
      int_pend_r <= 1'b0;
      ack_cnt_r <= 1'b0;
      o_rx_hunt <= 1'b1;
    end else begin
      o_rx_hunt <= hunt_r;
      ext_prev_r <= ext_live;
      if (ext_change && (armed_r || cmd_ext)) begin
        ext_latch_r <= ext_live;
        armed_r <= 1'b0;
        o_ext_status_req <= 1'b1;
      end else if (cmd_ext) begin
        ext_latch_r <= ext_live;
        armed_r <= 1'b1;
        o_ext_status_req <= 1'b0;
      end else if (armed_r) begin
        ext_latch_r <= ext_live;
      end
      if (ack_lead) ack_cnt_r <= ~ack_cnt_r;
      // A poll or acknowledge that sets the bit wins over end of interrupt.
      if (!mode_r[`MODE_VECTORED] && rd_vec && !pin_r[`PIN_PRI] &&
          i_int_request) int_pend_r <= 1'b1;
      else if (mode_r[`MODE_VECTORED] && ack_lead && ack_cnt_r &&
               !pin_r[`PIN_PRI] && i_int_request) int_pend_r <= 1'b1;
      else if (cmd_eoi && !i_other_pending) int_pend_r <= 1'b0;
    end
  end

  chk_break_low: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    tc_r.brk |=> !o_txd) else $error("break did not hold line low");
  chk_dtr_pin: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    ##1 o_dtr_n == !$past(tc_r.dtr)) else $error("dtr pin wrong");
  chk_rts_sync: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !mode_async && tc_r.rts |=> !o_rts_n) else $error("rts pin wrong");
  chk_rts_async_wait: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    mode_async && !tc_r.rts && !o_rts_n && !all_empty |=> !o_rts_n)
    else $error("rts rose early");
  chk_tbe_crc: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    phase_r == PH_CRC |-> !st.tbe) else $error("tbe set in crc");
  chk_idle_after_rst: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $rose(i_rst_n) |-> idle_r && st.tbe) else $error("reset state");
  chk_crc_sets_idle: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    load_crc |=> idle_r && phase_r == PH_CRC && bits_r == 5'h10)
    else $error("crc start wrong");
  chk_stuff_zero: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    tick && stuff |=> !line_r ##1 ones_r == 3'h0) else $error("no stuff");
  chk_ext_frozen: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !armed_r && !cmd_ext |=> $stable(ext_latch_r))
    else $error("latch moved");
  chk_hunt_cmd: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    cmd_hunt |=> hunt_r ##1 o_rx_hunt) else $error("hunt not entered");
  chk_len_eight: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    load_dat && !mode_async && tc_r.len == 2'h3 |=> bits_r == 5'h8)
    else $error("length wrong");
  chk_async_finish: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    mode_async && !tc_r.tx_en && bits_r > 5'h1 && !tick |=> $stable(bits_r))
    else $error("char cut short");
  cov_crc_sent: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    load_crc);
  cov_break: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    $rose(brk_r));
  cov_async_char: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    load_dat && mode_async);
endmodule : mps_tx_status

// *** serial_far_end.sv ***
// Far-end line and modem model: bit clocks, receive line, transmit capture.
`timescale 1ns/100ps
module serial_far_end (
  // Control from the bench.
  input wire logic i_run,
  input wire logic i_rx_low,
  input wire logic i_async,
  input wire logic [3:0] i_nbits,
  // Line side.
  input wire logic i_txd,
  output logic o_txc,
  output logic o_rxc,
  output logic o_rxd,
  // Captured traffic.
  output logic [15:0] o_win,
  output logic [7:0] o_char,
  output logic o_char_stb
);
  logic [7:0] sh;
  int cnt;
  // The bit clock stands still between bursts, so nothing may lean on it.
  initial begin
    o_txc = 1'b1;
    {o_win, o_char, o_char_stb, sh} = '0;
    cnt = -1;
    forever begin
      #80;
      if (i_run) o_txc = ~o_txc;
    end
  end
  assign o_rxc = o_txc;
  assign o_rxd = ~i_rx_low;
  // Sampling late in the cell keeps clear of the output's own delay.
  always @(posedge o_txc) begin
    #60;
    o_win = {i_txd, o_win[15:1]};
    if (!i_async) cnt = -1;
    else if (cnt < 0) begin
      if (!i_txd) cnt = 0;
    end else if (cnt < i_nbits) begin
      sh = {i_txd, sh[7:1]};
      cnt++;
    end else begin
      o_char = sh >> (4'd8 - i_nbits);
      o_char_stb = 1'b1;
      #20 o_char_stb = 1'b0;
      cnt = -1;
    end
  end
endmodule : serial_far_end

// *** multiprotocol_serial_tx_status_tb.sv ***
// Self-checking bench for the serial transmit and status block.
`timescale 1ns/100ps
`include "mps_tx_consts.svh"
module multiprotocol_serial_tx_status_tb;
  import mps_tx_pkg::*;
  logic i_clk, i_rst_n, awvalid, wvalid, bready, arvalid, rready, run;
  logic awready, wready, bvalid, arready, rvalid, txd, rts_n, dtr_n, ext_req;
  logic dcd_n, cts_n, sync_n, pri_n, ack_n, int_req, oth, rx_av, found;
  logic txc, rxc, rxd, rx_low, async_m, hunt, cstb, hit, d;
  logic [1:0] bresp, rresp;
  logic [3:0] nbits;
  logic [7:0] awaddr, araddr, vec, ch, r, s1, s2, w8, m8;
  logic [15:0] win, p;
  logic [31:0] wdata, rdata, seed, mk, rot;
  logic [33:0] exp_q[$];
  logic [31:0] msk_q[$];
  logic [7:0] chr_q[$];
  int n_mismatch, tests_run, k, j, n;
  tx_ctrl_s tc;
  mps_tx_status u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_awvalid(awvalid),
    .i_awaddr(awaddr), .i_wvalid(wvalid), .i_wdata(wdata), .i_wstrb(4'hf),
    .i_bready(bready), .i_arvalid(arvalid), .i_araddr(araddr),
    .i_rready(rready), .o_awready(awready), .o_wready(wready),
    .o_bvalid(bvalid), .o_bresp(bresp), .o_arready(arready),
    .o_rvalid(rvalid), .o_rdata(rdata), .o_rresp(rresp), .i_txc(txc),
    .i_rxc(rxc), .i_rxd(rxd), .i_dcd_n(dcd_n), .i_cts_n(cts_n),
    .i_sync_n(sync_n), .o_txd(txd), .o_rts_n(rts_n), .o_dtr_n(dtr_n),
    .i_priority_chain_in_n(pri_n), .i_interrupt_ack_strobe_n(ack_n),
    .i_int_request(int_req), .i_other_pending(oth), .i_rx_char_avail(rx_av),
    .i_sync_found(found), .i_vector_readback(vec),
    .o_ext_status_req(ext_req), .o_rx_hunt(hunt));
  serial_far_end u_far (.i_run(run), .i_rx_low(rx_low), .i_async(async_m),
    .i_nbits(nbits), .i_txd(txd), .o_txc(txc), .o_rxc(rxc), .o_rxd(rxd),
    .o_win(win), .o_char(ch), .o_char_stb(cstb));
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic close_out();
    $display("mismatches %0d, comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out
  task automatic cmp_data(input string nm, input logic [33:0] e, g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask : cmp_data
  task automatic cmp_pin(input string nm, input logic e, g);
    cmp_data(nm, {33'h0, e}, {33'h0, g});
  endtask : cmp_pin
  task automatic fail_wait(input string nm);
    n_mismatch++;
    $display("unexpected %s: expected answer, seen timeout", nm);
    close_out();
  endtask : fail_wait
  task automatic wr(input logic [7:0] a, v, input logic [1:0] rs = `RESP_OKAY);
    exp_q.push_back({rs, 32'h0});
    msk_q.push_back(32'h0);
    awaddr <= a;
    wdata <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge i_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    @(posedge i_clk);
    if (n == 40) fail_wait("write");
  endtask : wr
  task automatic rd(input logic [7:0] a, e, input logic [31:0] m = '1,
                    input logic [1:0] rs = `RESP_OKAY);
    exp_q.push_back({rs, {24'h0, e} & m});
    msk_q.push_back(m);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge i_clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    @(posedge i_clk);
    if (n == 40) fail_wait("read");
  endtask : rd
  task automatic drain();
    for (n = 0; n < 900 && chr_q.size() > 0; n++) @(posedge i_clk);
    if (n == 900) fail_wait("serial char");
  endtask : drain
  always @(posedge i_clk) begin
    if ((bvalid && bready) || (rvalid && rready)) begin
      mk = msk_q.pop_front();
      cmp_data("response", exp_q.pop_front(),
               bvalid ? {bresp, 32'h0} : {rresp, rdata & mk});
    end
  end
  always @(posedge cstb) cmp_data("char", {26'h0, chr_q.pop_front()}, {26'h0, ch});
  initial begin
    {i_rst_n, awvalid, wvalid, bready, arvalid, rready, run} = 7'h00;
    {rx_low, async_m, int_req, oth, found, ack_n, pri_n, sync_n} = 8'h07;
    {awaddr, araddr, wdata, nbits, vec} = 60'h0;
    seed = 32'h0000f143;
    {dcd_n, cts_n, rx_av} = 3'(rnd());
    repeat (16) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    cmp_pin("txd", 1'b1, txd);
    cmp_pin("hunt", 1'b1, hunt);
    repeat (4) @(posedge i_clk);
    wr(`ADDR_COMMAND, 8'h02);
    cmp_pin("ext req", 1'b0, ext_req);
    rd(`ADDR_PRIMARY_STATUS, {2'h1, ~cts_n, 1'b1, ~dcd_n, 2'h2, rx_av});
    d = ~dcd_n;
    dcd_n <= d;
    repeat (8) @(posedge i_clk);
    cmp_pin("ext req", 1'b1, ext_req);
    dcd_n <= ~d;
    rd(`ADDR_PRIMARY_STATUS, {4'h0, ~d, 3'h0}, 32'h08);
    wr(`ADDR_COMMAND, 8'h02);
    rd(`ADDR_PRIMARY_STATUS, {4'h0, d, 3'h0}, 32'h08);
    r = 8'(rnd());
    vec <= r;
    int_req <= 1'b1;
    pri_n <= 1'b0;
    repeat (4) @(posedge i_clk);
    rd(`ADDR_VECTOR, r);
    rd(`ADDR_PRIMARY_STATUS, 8'h02, 32'h02);
    wr(`ADDR_COMMAND, 8'h04);
    rd(`ADDR_PRIMARY_STATUS, 8'h00, 32'h02);
    wr(`ADDR_MODE, 8'h40);
    repeat (2) begin
      ack_n <= 1'b0;
      repeat (4) @(posedge i_clk);
      ack_n <= 1'b1;
      repeat (4) @(posedge i_clk);
    end
    rd(`ADDR_PRIMARY_STATUS, 8'h02, 32'h02);
    int_req <= 1'b0;
    wr(`ADDR_COMMAND, 8'h04);
    rd(`ADDR_PRIMARY_STATUS, 8'h00, 32'h02);
    wr(`ADDR_MODE, 8'h00);
    found <= 1'b1;
    @(posedge i_clk);
    found <= 1'b0;
    repeat (3) @(posedge i_clk);
    cmp_pin("hunt", 1'b0, hunt);
    rd(`ADDR_PRIMARY_STATUS, 8'h00, 32'h10);
    wr(`ADDR_COMMAND, 8'h01);
    cmp_pin("hunt", 1'b1, hunt);
    wr(`ADDR_MODE, 8'h01);
    wr(`ADDR_COMMAND, 8'h02);
    run <= 1'b1;
    rx_low <= 1'b1;
    repeat (128) @(posedge i_clk);
    rd(`ADDR_PRIMARY_STATUS, 8'h80, 32'h80);
    rx_low <= 1'b0;
    repeat (32) @(posedge i_clk);
    wr(`ADDR_COMMAND, 8'h02);
    rd(`ADDR_PRIMARY_STATUS, 8'h00, 32'h80);
    s1 = 8'(rnd());
    s2 = 8'(rnd());
    wr(`ADDR_SYNC_FIRST, s1);
    for (k = 0; k < 4; k++) begin
      wr(`ADDR_SYNC_SECOND, (k == 2) ? `HDLC_FLAG : s2);
      wr(`ADDR_MODE, {4'h0, 2'(k), 2'h0});
      tc = '0;
      {tc.tx_en, tc.rts, tc.dtr} = 3'h7;
      tc.poly16 = (k != 2);
      wr(`ADDR_TX_CONTROL, tc);
      repeat (320) @(posedge i_clk);
      p = (k == 1) ? {s2, s1} : (k == 2) ? {2{`HDLC_FLAG}} : {2{s1}};
      hit = 1'b0;
      for (j = 0; j < 16; j++) begin
        rot = {p, p} >> j;
        hit = hit | (rot[15:0] === win);
      end
      cmp_pin("idle pattern", 1'b1, hit);
      cmp_pin("rts", 1'b0, rts_n);
      cmp_pin("dtr", 1'b0, dtr_n);
      wr(`ADDR_TX_CONTROL, 8'h00);
      cmp_pin("rts", 1'b1, rts_n);
      repeat (160) @(posedge i_clk);
      cmp_pin("idle mark", 1'b1, txd);
    end
    wr(`ADDR_MODE, 8'h00);
    wr(`ADDR_COMMAND, 8'h0a);
    tc = '0;
    {tc.tx_en, tc.crc_en, tc.poly16, tc.len} = 5'h1f;
    wr(`ADDR_TX_CONTROL, tc);
    wr(`ADDR_TX_DATA, s2);
    rd(`ADDR_PRIMARY_STATUS, 8'h00, 32'h40);
    repeat (360) @(posedge i_clk);
    cmp_pin("ext req", 1'b1, ext_req);
    rd(`ADDR_PRIMARY_STATUS, 8'h44, 32'h44);
    wr(`ADDR_TX_CONTROL, 8'h00);
    repeat (160) @(posedge i_clk);
    wr(`ADDR_MODE, 8'h01);
    async_m <= 1'b1;
    for (k = 0; k < 8; k++) begin
      n = (k < 5) ? k + 1 : (k == 5) ? 7 : (k == 6) ? 6 : 8;
      m8 = 8'((1 << n) - 1);
      r = 8'(rnd());
      w8 = (k < 5) ? ((8'hff << (n + 3)) | (r & m8)) : r;
      tc = '0;
      {tc.tx_en, tc.rts, tc.dtr} = {2'h3, k[0]};
      tc.len = (k < 5) ? 2'h0 : 2'(k - 4);
      nbits <= 4'(n);
      wr(`ADDR_TX_CONTROL, tc);
      repeat (24) @(posedge i_clk);
      cmp_pin("txd", 1'b1, txd);
      cmp_pin("dtr", ~k[0], dtr_n);
      chr_q.push_back(r & m8);
      wr(`ADDR_TX_DATA, w8);
      drain();
    end
    r = 8'(rnd());
    chr_q.push_back(r);
    wr(`ADDR_TX_DATA, r);
    repeat (40) @(posedge i_clk);
    {tc.rts, tc.tx_en} = 2'h0;
    wr(`ADDR_TX_CONTROL, tc);
    cmp_pin("rts", 1'b0, rts_n);
    drain();
    repeat (16) @(posedge i_clk);
    cmp_pin("rts", 1'b1, rts_n);
    async_m <= 1'b0;
    {tc.tx_en, tc.brk} = 2'h3;
    wr(`ADDR_TX_CONTROL, tc);
    cmp_pin("break", 1'b0, txd);
    tc.brk = 1'b0;
    wr(`ADDR_TX_CONTROL, tc);
    cmp_pin("break", 1'b1, txd);
    rd(8'h20, 8'h00, 32'h0, `RESP_DECERR);
    wr(8'h24, 8'h00, `RESP_DECERR);
    close_out();
  end
endmodule : multiprotocol_serial_tx_status_tb
